// ===== design/spio_pkg.sv
// Constants shared by the shared-pin I/O port block.
// Assumes a 40 MHz system clock and a plain strobe register port.
package spio_pkg;
  localparam int          SPIO_PORT_W       = 16;
  localparam int          SPIO_CN_W         = 31;
  localparam int          SPIO_RP_W         = 26;
  localparam int          SPIO_ADDR_W       = 4;
  localparam logic [3:0]  SPIO_OFF_DIR      = 4'h0;
  localparam logic [3:0]  SPIO_OFF_LAT      = 4'h1;
  localparam logic [3:0]  SPIO_OFF_LVL      = 4'h2;
  localparam logic [3:0]  SPIO_OFF_ODC      = 4'h3;
  localparam logic [3:0]  SPIO_OFF_ANA      = 4'h4;
  localparam logic [3:0]  SPIO_OFF_CNEN_LO  = 4'h5;
  localparam logic [3:0]  SPIO_OFF_CNEN_HI  = 4'h6;
  localparam logic [3:0]  SPIO_OFF_CNPU_LO  = 4'h7;
  localparam logic [3:0]  SPIO_OFF_CNPU_HI  = 4'h8;
  localparam logic [3:0]  SPIO_OFF_CN_STAT  = 4'h9;
  localparam logic [15:0] SPIO_RST_DIR      = 16'hffff;
  localparam logic [15:0] SPIO_RST_LAT      = 16'h0000;
  localparam logic [15:0] SPIO_RST_ODC      = 16'h0000;
  localparam logic [15:0] SPIO_RST_ANA      = 16'h0000;
  localparam logic [15:0] SPIO_RST_CN       = 16'h0000;
  localparam int          SPIO_CN_FLAG_BIT  = 0;
endpackage

// ===== design/spio_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the inputs come from pads outside the clk_sys domain.
module spio_sync
  import spio_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // spio_sync

// ===== design/spio_cn_detect.sv
// Change-notification detector over the synchronised pin levels.
// Assumes levels are already in the clk_sys domain.
module spio_cn_detect
  import spio_pkg::*;
#(
  parameter int W = 31
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] enable,
  output logic              change
);
  logic [W-1:0] prev;
  logic [W-1:0] diff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_cmp
      assign diff[i] = enable[i] & (level[i] ^ prev[i]);
    end
  endgenerate

  assign change = |diff;
endmodule // spio_cn_detect

// ===== design/spio_port.sv
// Shared-pin parallel I/O port with change notification.
// Assumes a strobe register port on clk_sys and asynchronous pads outside.
module spio_port
  import spio_pkg::*;
#(
  parameter int          PORT_W   = SPIO_PORT_W,
  parameter int          CN_W     = SPIO_CN_W,
  parameter logic [15:0] IMPL_MSK = 16'hffff,
  parameter logic [15:0] ANA_MSK  = 16'h003f,
  parameter logic [15:0] RP_MSK   = 16'hffff
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  input  wire logic [PORT_W-1:0] periph_en,
  input  wire logic [PORT_W-1:0] periph_oe,
  input  wire logic [PORT_W-1:0] periph_out,
  output logic      [PORT_W-1:0] periph_in,
  output logic      [PORT_W-1:0] analog_sel,
  input  wire logic [CN_W-1:0]   cn_pin_in,
  output logic      [CN_W-1:0]   cn_pullup_en,
  output logic                   cn_irq,
  input  wire logic              cn_irq_ack,
  output logic                   cn_wake
);
  logic [15:0]       pin_direction_reg;
  logic [15:0]       output_latch_reg;
  logic [15:0]       open_drain_select_reg;
  logic [15:0]       analog_pin_config_low;
  logic [15:0]       change_notify_enable_lo;
  logic [15:0]       change_notify_enable_hi;
  logic [15:0]       weak_pullup_enable_lo;
  logic [15:0]       weak_pullup_enable_hi;
  logic [PORT_W-1:0] pin_sync;
  logic [CN_W-1:0]   cn_sync;
  logic [CN_W-1:0]   cn_en;
  logic [15:0]       pin_level_view;
  logic              cn_change;
  logic [15:0]       next_rdata;
  logic [PORT_W-1:0] next_oe;
  logic [PORT_W-1:0] next_out;
  logic [PORT_W-1:0] next_pin_in;
  logic              wr_ok;

  // Writes with the read strobe high are ignored so one cycle never does both.
  assign wr_ok = reg_wr & ~reg_rd;

  spio_sync #(.W(PORT_W)) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Change pins get their own synchroniser, as they are separate pads.
  spio_sync #(.W(CN_W)) u_cn_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (cn_pin_in),
    .sync_out (cn_sync)
  );

  assign cn_en = {change_notify_enable_hi[CN_W-17:0], change_notify_enable_lo};

  spio_cn_detect #(.W(CN_W)) u_cn (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .level   (cn_sync),
    .enable  (cn_en),
    .change  (cn_change)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_direction_reg <= SPIO_RST_DIR;
    end else if (wr_ok && reg_addr == SPIO_OFF_DIR) begin
      pin_direction_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      output_latch_reg <= SPIO_RST_LAT;
    end else if (wr_ok && (reg_addr == SPIO_OFF_LAT || reg_addr == SPIO_OFF_LVL)) begin
      output_latch_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      open_drain_select_reg <= SPIO_RST_ODC;
    end else if (wr_ok && reg_addr == SPIO_OFF_ODC) begin
      open_drain_select_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_pin_config_low <= SPIO_RST_ANA;
    end else if (wr_ok && reg_addr == SPIO_OFF_ANA) begin
      analog_pin_config_low <= reg_wdata;
    end
  end

  // Bit 15 of the high halves has no pin behind it and reads zero.
  // enable registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      change_notify_enable_lo <= SPIO_RST_CN;
      change_notify_enable_hi <= SPIO_RST_CN;
      weak_pullup_enable_lo   <= SPIO_RST_CN;
      weak_pullup_enable_hi   <= SPIO_RST_CN;
    end else if (wr_ok) begin
      if (reg_addr == SPIO_OFF_CNEN_LO) begin
        change_notify_enable_lo <= reg_wdata;
      end
      if (reg_addr == SPIO_OFF_CNEN_HI) begin
        change_notify_enable_hi <= {1'b0, reg_wdata[14:0]};
      end
      if (reg_addr == SPIO_OFF_CNPU_LO) begin
        weak_pullup_enable_lo <= reg_wdata;
      end
      if (reg_addr == SPIO_OFF_CNPU_HI) begin
        weak_pullup_enable_hi <= {1'b0, reg_wdata[14:0]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cn_pullup_en <= '0;
    end else begin
      cn_pullup_en <= {weak_pullup_enable_hi[CN_W-17:0], weak_pullup_enable_lo};
    end
  end

  // The set branch comes first so a change in the ack cycle is never lost.
  // sticky request, set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cn_irq <= 1'b0;
    end else if (cn_change) begin
      cn_irq <= 1'b1;
    end else if (cn_irq_ack) begin
      cn_irq <= 1'b0;
    end
  end

  // wake on enabled change
  // A real pad would wake with an asynchronous XOR cell; here it is the
  // clocked change seen on the third clk_sys edge after the pin moves, a known limitation.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cn_wake <= 1'b0;
    end else begin
      cn_wake <= cn_change;
    end
  end

  assign pin_level_view = pin_sync & ~(~analog_pin_config_low & ANA_MSK) & IMPL_MSK;

  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      SPIO_OFF_DIR:     next_rdata = pin_direction_reg & IMPL_MSK;
      SPIO_OFF_LAT:     next_rdata = output_latch_reg & IMPL_MSK;
      SPIO_OFF_LVL:     next_rdata = pin_level_view;
      SPIO_OFF_ODC:     next_rdata = open_drain_select_reg & IMPL_MSK;
      SPIO_OFF_ANA:     next_rdata = analog_pin_config_low;
      SPIO_OFF_CNEN_LO: next_rdata = change_notify_enable_lo;
      SPIO_OFF_CNEN_HI: next_rdata = change_notify_enable_hi;
      SPIO_OFF_CNPU_LO: next_rdata = weak_pullup_enable_lo;
      SPIO_OFF_CNPU_HI: next_rdata = weak_pullup_enable_hi;
      SPIO_OFF_CN_STAT: next_rdata = {15'h0000, cn_irq};
      default:          next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Pin ownership: peripheral first, then port, per bit.
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      logic per_own;
      logic drv;
      logic val;
      // only remappable pins take peripheral drive
      assign per_own = periph_en[i] & periph_oe[i] & RP_MSK[i];
      assign drv = per_own ? 1'b1 : (~pin_direction_reg[i] & IMPL_MSK[i]);
      assign val = per_own ? periph_out[i] : output_latch_reg[i];
      assign next_oe[i]  = drv & ~(open_drain_select_reg[i] & val);
      assign next_out[i] = open_drain_select_reg[i] ? 1'b0 : val;
      // An open-drain release still shows the port's own high, so it stays blocked.
      // no loop through
      assign next_pin_in[i] = periph_en[i] & ~(~per_own & ~pin_direction_reg[i]) & pin_sync[i];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_oe     <= '0;
      pin_out    <= '0;
      periph_in  <= '0;
      analog_sel <= '0;
    end else begin
      pin_oe     <= next_oe;
      pin_out    <= next_out;
      periph_in  <= next_pin_in;
      // Pins outside the analog mask never report analog mode.
      analog_sel <= ~analog_pin_config_low & ANA_MSK;
    end
  end

  // Per-pin assertions watch bit 0 only; the logic per bit is one generate loop.
  // reset leaves pins undriven
  a_reset_input : assert property (@(posedge clk_sys) !rst_n |=> pin_oe == '0)
    else $error("pin driven after reset");
  a_cn_request : assert property (@(posedge clk_sys) disable iff (!rst_n)
    cn_change |=> cn_irq)
    else $error("change did not raise request");
  a_periph_owns : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (periph_en[0] && periph_oe[0] && RP_MSK[0] && !open_drain_select_reg[0]) |=> pin_oe[0])
    else $error("peripheral drive lost");
  a_port_drives : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!periph_oe[0] && !pin_direction_reg[0] && !open_drain_select_reg[0] && IMPL_MSK[0])
    |=> pin_oe[0] && pin_out[0] == $past(output_latch_reg[0]))
    else $error("port did not drive pin");
  a_dir_input : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pin_direction_reg[0] && !periph_oe[0]) |=> !pin_oe[0])
    else $error("input pin driven");
  a_od_low_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(open_drain_select_reg[0]) |-> !(pin_oe[0] && pin_out[0]))
    else $error("open drain drove high");
  a_od_sinks_low : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (open_drain_select_reg[0] && !pin_direction_reg[0] && !periph_oe[0] && !output_latch_reg[0] && IMPL_MSK[0])
    |=> pin_oe[0] && !pin_out[0])
    else $error("open drain did not sink low");
  a_no_loop : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!periph_oe[0] && !pin_direction_reg[0]) |=> !periph_in[0])
    else $error("port output looped into peripheral");
  a_latch_write : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ok && reg_addr == SPIO_OFF_LVL) |=> output_latch_reg == $past(reg_wdata))
    else $error("level write missed latch");
  a_rdata_idle : assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero after idle cycle");
  a_unimpl_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && (reg_addr == SPIO_OFF_DIR || reg_addr == SPIO_OFF_LAT || reg_addr == SPIO_OFF_LVL))
    |=> (reg_rdata & ~IMPL_MSK) == 16'h0000)
    else $error("unimplemented bit read nonzero");
  a_analog_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == SPIO_OFF_LVL && ANA_MSK[0] && !analog_pin_config_low[0])
    |=> !reg_rdata[0])
    else $error("analog pin read nonzero");
  a_level_pins : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == SPIO_OFF_LVL && IMPL_MSK[0] && !(ANA_MSK[0] && !analog_pin_config_low[0]))
    |=> reg_rdata[0] == $past(pin_sync[0]))
    else $error("level read not taken from pin");
  a_cn_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cn_irq && !cn_irq_ack) |=> cn_irq)
    else $error("request dropped without ack");
  a_cn_wake : assert property (@(posedge clk_sys) disable iff (!rst_n)
    cn_change |=> cn_wake)
    else $error("change did not raise wake");
  a_cn_pin0 : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (change_notify_enable_lo[0] && cn_sync[0] != $past(cn_sync[0])) |=> cn_irq)
    else $error("enabled pin change missed");

  // Main scenarios: request, peripheral drive, open drain, ack, level read.
  c_cn_irq    : cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(cn_irq));
  c_periph    : cover property (@(posedge clk_sys) disable iff (!rst_n) periph_oe[0] && periph_en[0]);
  c_od_drive  : cover property (@(posedge clk_sys) disable iff (!rst_n) open_drain_select_reg[0] && pin_oe[0]);
  c_cn_ack    : cover property (@(posedge clk_sys) disable iff (!rst_n) cn_irq && cn_irq_ack);
  c_lvl_read  : cover property (@(posedge clk_sys) disable iff (!rst_n) reg_rd && reg_addr == SPIO_OFF_LVL);
endmodule // spio_port

// ===== tb/spio_pad_model.sv
// Pad model standing outside the shared-pin port: sets the level seen on each pad.
// Assumes an external pull-up on every pad, so a pad nobody drives reads high.
module spio_pad_model
  import spio_pkg::*;
(
  input  wire logic [SPIO_PORT_W-1:0] pin_out,
  input  wire logic [SPIO_PORT_W-1:0] pin_oe,
  input  wire logic [SPIO_PORT_W-1:0] ext_val,
  input  wire logic [SPIO_PORT_W-1:0] ext_oe,
  output logic      [SPIO_PORT_W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // The pull-up is what lets an open-drain high show as a real one.
  always_comb begin
    for (int i = 0; i < SPIO_PORT_W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule // spio_pad_model

// ===== tb/tb_shared_pin_io_port.sv
// Random self-checking bench for the shared-pin I/O port.
// Assumes the pad model beside the block and a 40 MHz clock made here.
module tb_shared_pin_io_port
  import spio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] IMPL = 16'h7fff;
  localparam logic [15:0] ANA  = 16'h003f;
  logic        clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cn_irq, cn_wake, cn_irq_ack = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, pin_in, pin_out, pin_oe, periph_in, analog_sel;
  logic [15:0] periph_en = 16'h0, periph_oe = 16'h0, periph_out = 16'h0, ext_val = 16'h0, ext_oe = 16'h0;
  logic [15:0] dir, lat, odc, ana, own, eoe, eout, pins;
  logic [30:0] cn_pin_in = 31'h0, cn_pullup_en;
  logic [31:0] w;
  logic        hit, wk;
  int          seed = 79890, error_cnt = 0, checks = 0, cyc = 0;
  int          ks[4] = '{0, 30, 16, 7};

  spio_port #(.IMPL_MSK(IMPL)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_en(periph_en), .periph_oe(periph_oe),
    .periph_out(periph_out), .periph_in(periph_in), .analog_sel(analog_sel), .cn_pin_in(cn_pin_in),
    .cn_pullup_en(cn_pullup_en), .cn_irq(cn_irq), .cn_irq_ack(cn_irq_ack), .cn_wake(cn_wake));
  spio_pad_model i_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] dt);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= dt;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // one idle cycle precedes each read.
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk({16'h0, reg_rdata}, {16'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Level a pad settles to once the block drives what the settings say it should.
  function automatic logic [15:0] pad_lvl(input logic [15:0] oe, out, ev, eo);
    return (oe & out) | (~oe & eo & ev) | (~oe & ~eo);
  endfunction

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(SPIO_OFF_DIR, SPIO_RST_DIR & IMPL);
    rchk(SPIO_OFF_ANA, SPIO_RST_ANA);
    rchk(SPIO_OFF_LAT, SPIO_RST_LAT);
    rchk(4'hf, 16'h0);
    chk({16'h0, analog_sel}, {16'h0, ANA & IMPL});
    chk({16'h0, pin_oe}, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      dir = (i == 0) ? 16'h0 : $random(seed);
      lat = (i == 1) ? 16'h5555 : $random(seed);
      own = (i < 2) ? 16'h0 : $random(seed) & $random(seed);
      odc = (i == 1) ? 16'hffff : ((i == 0) ? 16'h0 : $random(seed) & ~own);
      ana = $random(seed);
      dir = dir | (ANA & ~ana);
      eout = $random(seed);
      // Expected drive: a driving peripheral wins, else the direction bit, open-drain only pulls low.
      eoe = (own | (~dir & ~(odc & lat))) & IMPL;
      eout = (own & eout) | (~own & ~odc & lat);
      wr(SPIO_OFF_DIR, dir);
      wr(i[0] ? SPIO_OFF_LVL : SPIO_OFF_LAT, lat);
      wr(SPIO_OFF_ODC, odc);
      wr(SPIO_OFF_ANA, ana);
      periph_en  <= own | $random(seed);
      periph_oe  <= own;
      periph_out <= eout & own;
      ext_val    <= $random(seed);
      ext_oe     <= ~eoe;
      repeat (6) @(posedge clk_sys);
      #1 pins = pad_lvl(eoe, eout, ext_val, ext_oe);
      chk({16'h0, pin_oe & IMPL}, {16'h0, eoe});
      chk({16'h0, pin_out & eoe}, {16'h0, eout & eoe});
      chk({16'h0, periph_in & IMPL}, {16'h0, pins & periph_en & (own | dir) & IMPL});
      chk({16'h0, analog_sel}, {16'h0, ANA & ~ana & IMPL});
      rchk(SPIO_OFF_LAT, lat & IMPL);
      rchk(SPIO_OFF_DIR, dir & IMPL);
      rchk(SPIO_OFF_LVL, pins & IMPL & ~(ANA & ~ana));
      rchk(SPIO_OFF_ODC, odc & IMPL);
      rchk(SPIO_OFF_ANA, ana);
    end
    $display("port test done");
    w = ($random(seed) | 32'h40000081) & 32'h7ffeffff;
    wr(SPIO_OFF_CNEN_LO, w[15:0]);
    wr(SPIO_OFF_CNEN_HI, {1'b0, w[30:16]});
    // change pins here are inputs only.
    wr(SPIO_OFF_CNPU_LO, ~w[15:0]);
    wr(SPIO_OFF_CNPU_HI, {1'b0, ~w[30:16]});
    rchk(SPIO_OFF_CNEN_HI, {1'b0, w[30:16]});
    rchk(SPIO_OFF_CNPU_LO, ~w[15:0]);
    rchk(SPIO_OFF_CNEN_LO, w[15:0]);
    rchk(SPIO_OFF_CNPU_HI, {1'b0, ~w[30:16]});
    chk({1'b0, cn_pullup_en}, {1'b0, ~w[30:0]});
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_sys);
      cn_pin_in[ks[j%4]] <= ~cn_pin_in[ks[j%4]];
      hit = 1'b0;
      wk  = 1'b0;
      repeat (8) begin
        @(posedge clk_sys);
        #1 hit = hit | cn_irq;
        wk = wk | cn_wake;
      end
      chk({31'h0, hit}, {31'h0, w[ks[j%4]]});
      chk({31'h0, wk}, {31'h0, w[ks[j%4]]});
      rchk(SPIO_OFF_CN_STAT, {15'h0, hit});
      @(posedge clk_sys);
      cn_irq_ack <= 1'b1;
      @(posedge clk_sys);
      cn_irq_ack <= 1'b0;
      @(posedge clk_sys);
      #1 chk({31'h0, cn_irq}, 32'h0);
    end
    $display("change notify test done");
    tally_and_finish;
  end
endmodule // tb_shared_pin_io_port
